// file: logic/snf_pkg.sv
// shared constants and types for the serial flash pin front end
`default_nettype none
package snf_pkg;
	localparam int BYTE_W = 8;
	localparam int COL_W = 12;
	localparam int ROW_W = 16;
	localparam int PAGE_W = 6;
	localparam int PIN_W = 4;
	localparam int PIN_GUARD = 2;
	localparam int PIN_PAUSE = 3;
	localparam logic [COL_W-1:0] COL_LAST_ECC_OFF = 12'h87f;
	localparam logic [COL_W-1:0] COL_LAST_ECC_ON = 12'h83f;
	localparam logic [3:0] STEP_1 = 4'h1;
	localparam logic [3:0] STEP_2 = 4'h2;
	localparam logic [3:0] STEP_4 = 4'h4;
	localparam logic [3:0] BYTE_CNT = 4'h8;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [PIN_W-1:0] OE_NONE = 4'h0;
	localparam logic [PIN_W-1:0] OE_SINGLE = 4'h2;
	localparam logic [PIN_W-1:0] OE_DUAL = 4'h3;
	localparam logic [PIN_W-1:0] OE_QUAD = 4'hf;
	localparam logic [5:0] SYNC_RST = 6'h3f;
	typedef enum logic [3:0] {
		W_SINGLE = 4'b0001,
		W_DUAL = 4'b0010,
		W_QUAD = 4'b0100,
		W_DTR = 4'b1000
	} snf_width_e;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ACTIVE = 4'b0010,
		ST_PAUSED = 4'b0100,
		ST_LOCKED = 4'b1000
	} snf_state_e;
endpackage : snf_pkg
`default_nettype wire

// file: logic/snf_byte_if.sv
// byte stream carrier between the pin front end and its buffer
`timescale 1ns/1ps
`default_nettype none
interface snf_byte_if;
	logic valid;
	logic ready;
	logic [7:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : snf_byte_if
`default_nettype wire

// file: logic/snf_pair_buf.sv
// two-entry buffer for received bytes, head entry drives the output
`timescale 1ns/1ps
`default_nettype none
module snf_pair_buf (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	snf_byte_if.snk i_fill,
	snf_byte_if.src o_drain
);
	logic [7:0] head_r, head_nxt, tail_r, tail_nxt;
	logic head_v_r, head_v_nxt, tail_v_r, tail_v_nxt;
	logic push, pop;

	assign i_fill.ready = ~tail_v_r;
	assign o_drain.valid = head_v_r;
	assign o_drain.data = head_r;

	always_comb begin
		push = i_fill.valid & ~tail_v_r;
		pop = head_v_r & o_drain.ready;
		head_nxt = head_r;
		tail_nxt = tail_r;
		head_v_nxt = head_v_r;
		tail_v_nxt = tail_v_r;
		if (pop) begin
			if (tail_v_r) begin
				head_nxt = tail_r;
				tail_v_nxt = 1'b0;
			end else begin
				head_v_nxt = 1'b0;
			end
		end
		if (push) begin
			if (!head_v_nxt) begin
				head_nxt = i_fill.data;
				head_v_nxt = 1'b1;
			end else begin
				tail_nxt = i_fill.data;
				tail_v_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			head_r <= 8'h00;
			tail_r <= 8'h00;
			head_v_r <= 1'b0;
			tail_v_r <= 1'b0;
		end else begin
			head_r <= head_nxt;
			tail_r <= tail_nxt;
			head_v_r <= head_v_nxt;
			tail_v_r <= tail_v_nxt;
		end
	end
endmodule : snf_pair_buf
`default_nettype wire

// file: logic/snf_front_end.sv
// serial flash pin front end: lane widths, pause, write guard, read strobe
// Functional notes
// [RL1] accept clock modes 0 and 3 only
// [RL2] sample on rising, launch on falling edge
// [RL3] host keeps clock idle while deselected
// [RL4] deselected with idle clock means idle
// [RL5] dual commands use lanes 0 and 1
// [RL6] quad commands also take guard, pause pins
// [RL7] double rate quad moves data both edges
// [RL8] double rate read needs quad enable set
// [RL9] pause works only with quad enable clear
// [RL10] pause halts only the serial link
// [RL11] pause starts at pause low, clock low
// [RL12] pause ends at pause high, clock low
// [RL13] paused: output floats, input and clock ignored
// [RL14] deselect in pause resets; release first
// [RL15] guard low blocks protection bit writes
// [RL16] guard applies only with quad enable clear
// [RL17] strobe low on accept, toggles when valid
// [RL18] strobe toggles at clock rate, both edges
// [RL19] column 12 bits, bound 2175 or 2111
// [RL20] row low six page, upper ten block
// [RL21] ecc on: first 64 spare programmable
// [RL22] ecc off: whole spare area programmable
// [RL23] ecc on by default, off widens page
// [RL24] host keeps column within valid bound
`timescale 1ns/1ps
`default_nettype none
module snf_front_end (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic [3:0] i_data_io,
	output logic [3:0] o_data_io,
	output logic [3:0] o_data_io_oe,
	output logic o_read_strobe,
	output logic o_read_strobe_oe,
	input wire logic i_quad_io_enable,
	input wire logic i_ecc_enable,
	input wire logic i_protect_bits_write_disable,
	input wire snf_pkg::snf_width_e i_bus_width,
	input wire logic i_drive_out,
	input wire logic i_strobe_cmd,
	input wire logic i_strobe_data_valid,
	input wire logic [7:0] i_tx_data,
	output logic o_tx_take,
	output logic o_rx_valid,
	output logic [7:0] o_rx_data,
	input wire logic i_rx_ready,
	output logic o_rx_overrun,
	output logic o_paused,
	output logic o_if_reset,
	output logic o_mode3,
	output logic o_protect_write_ok,
	input wire logic [11:0] i_column_address,
	input wire logic [15:0] i_row_address,
	output logic [5:0] o_page_index,
	output logic [9:0] o_block_index,
	output logic o_column_readable,
	output logic o_column_programmable
);
	snf_byte_if rx_in ();
	snf_byte_if rx_out ();

	logic [5:0] s1_r, s2_r;
	logic sclk_prev_r;
	logic cs_n_s, sclk_s, pause_s, guard_s;
	logic [3:0] dio_s;

	snf_pkg::snf_state_e st_r, st_nxt;
	snf_pkg::snf_width_e eff_w;
	logic rise, fall, is_dtr, samp, launch, is_last;
	logic [3:0] step, rx_sum, tx_sum;
	logic [7:0] rx_shift, tx_src, tx_rest;
	logic [3:0] tx_bits, oe_pat;
	logic [7:0] rx_sh_r, rx_sh_nxt, rx_byte_r, rx_byte_nxt;
	logic [7:0] tx_sh_r, tx_sh_nxt;
	logic [3:0] rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
	logic push_r, push_nxt, take_r, take_nxt;
	logic [3:0] io_r, io_nxt, oe_r, oe_nxt;
	logic strobe_r, strobe_nxt, strobe_oe_r, strobe_oe_nxt;
	logic overrun_r, overrun_nxt, paused_r, paused_nxt;
	logic if_reset_r, if_reset_nxt, mode3_r, mode3_nxt;
	logic prot_ok_r, prot_ok_nxt, col_rd_r, col_rd_nxt;
	logic col_pg_r, col_pg_nxt;
	logic [5:0] page_r, page_nxt;
	logic [9:0] block_r, block_nxt;

	snf_pair_buf u_buf (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_fill(rx_in.snk),
		.o_drain(rx_out.src)
	);

	assign rx_in.valid = push_r;
	assign rx_in.data = rx_byte_r;
	assign rx_out.ready = i_rx_ready;
	assign o_rx_valid = rx_out.valid;
	assign o_rx_data = rx_out.data;

	// pins are asynchronous to i_clk_sys; only s2_r is ever looked at
	assign cs_n_s = s2_r[5];
	assign sclk_s = s2_r[4];
	assign dio_s = s2_r[3:0];
	assign pause_s = dio_s[snf_pkg::PIN_PAUSE];
	assign guard_s = dio_s[snf_pkg::PIN_GUARD];

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			s1_r <= snf_pkg::SYNC_RST;
			s2_r <= snf_pkg::SYNC_RST;
			// matches the synchroniser reset so no false edge follows reset
			sclk_prev_r <= 1'b1;
		end else begin
			s1_r <= {i_cs_n, i_sclk, i_data_io};
			s2_r <= s1_r;
			sclk_prev_r <= sclk_s;
		end
	end

	always_comb begin
		eff_w = i_bus_width;
		if (i_bus_width == snf_pkg::W_DTR && !i_quad_io_enable) begin
			eff_w = snf_pkg::W_QUAD; // see [RL8]
		end
		is_dtr = (eff_w == snf_pkg::W_DTR);
		rise = sclk_s & ~sclk_prev_r;
		fall = ~sclk_s & sclk_prev_r;
		tx_src = (tx_cnt_r == snf_pkg::CNT_ZERO) ? i_tx_data : tx_sh_r;
		case (eff_w)
			snf_pkg::W_SINGLE: begin
				step = snf_pkg::STEP_1;
				rx_shift = {rx_sh_r[6:0], dio_s[0]};
				tx_bits = {2'h0, tx_src[7], 1'b0};
				tx_rest = {tx_src[6:0], 1'b0};
				oe_pat = snf_pkg::OE_SINGLE;
			end
			snf_pkg::W_DUAL: begin
				step = snf_pkg::STEP_2; // see [RL5]
				rx_shift = {rx_sh_r[5:0], dio_s[1:0]};
				tx_bits = {2'h0, tx_src[7:6]};
				tx_rest = {tx_src[5:0], 2'h0};
				oe_pat = snf_pkg::OE_DUAL;
			end
			default: begin
				step = snf_pkg::STEP_4; // see [RL6]
				rx_shift = {rx_sh_r[3:0], dio_s};
				tx_bits = tx_src[7:4];
				tx_rest = {tx_src[3:0], 4'h0};
				oe_pat = snf_pkg::OE_QUAD;
			end
		endcase
		rx_sum = rx_cnt_r + step;
		tx_sum = tx_cnt_r + step;
		st_nxt = st_r;
		mode3_nxt = mode3_r;
		if_reset_nxt = 1'b0;
		case (st_r)
			snf_pkg::ST_IDLE: begin
				// idle clock level at select picks mode 0 or 3
				if (!cs_n_s) begin
					st_nxt = snf_pkg::ST_ACTIVE;
					mode3_nxt = sclk_s; // see [RL1]
				end
			end
			snf_pkg::ST_ACTIVE: begin
				if (cs_n_s) begin
					st_nxt = snf_pkg::ST_IDLE; // see [RL4]
				end else if (!i_quad_io_enable && !pause_s && !sclk_s) begin
					st_nxt = snf_pkg::ST_PAUSED; // see [RL9] see [RL11]
				end
			end
			snf_pkg::ST_PAUSED: begin
				if (cs_n_s) begin
					st_nxt = snf_pkg::ST_LOCKED; // see [RL14]
					if_reset_nxt = 1'b1;
				end else if (i_quad_io_enable || (pause_s && !sclk_s)) begin
					st_nxt = snf_pkg::ST_ACTIVE; // see [RL12]
				end
			end
			snf_pkg::ST_LOCKED: begin
				// a new select is only honoured once pause is released
				if (cs_n_s && (pause_s || i_quad_io_enable)) begin
					st_nxt = snf_pkg::ST_IDLE; // see [RL14]
				end
			end
			default: begin
				st_nxt = snf_pkg::ST_IDLE;
			end
		endcase
		// edges only count while staying active, so a pause ignores the clock
		is_last = (st_r == snf_pkg::ST_ACTIVE) && (st_nxt == snf_pkg::ST_ACTIVE);
		samp = is_last && !i_drive_out && (rise || (is_dtr && fall)); // see [RL2] see [RL7]
		launch = is_last && i_drive_out && (fall || (is_dtr && rise)); // see [RL2] see [RL7]
		rx_sh_nxt = rx_sh_r;
		rx_cnt_nxt = rx_cnt_r;
		rx_byte_nxt = rx_byte_r;
		push_nxt = 1'b0;
		tx_sh_nxt = tx_sh_r;
		tx_cnt_nxt = tx_cnt_r;
		take_nxt = 1'b0;
		io_nxt = io_r;
		if (samp) begin
			rx_sh_nxt = rx_shift;
			if (rx_sum == snf_pkg::BYTE_CNT) begin
				rx_cnt_nxt = snf_pkg::CNT_ZERO;
				rx_byte_nxt = rx_shift;
				push_nxt = 1'b1;
			end else begin
				rx_cnt_nxt = rx_sum;
			end
		end
		if (launch) begin
			take_nxt = (tx_cnt_r == snf_pkg::CNT_ZERO);
			io_nxt = tx_bits;
			tx_sh_nxt = tx_rest;
			tx_cnt_nxt = (tx_sum == snf_pkg::BYTE_CNT) ? snf_pkg::CNT_ZERO : tx_sum;
		end
		// a pause keeps partial bytes; only deselect clears them
		if (st_nxt == snf_pkg::ST_IDLE || st_nxt == snf_pkg::ST_LOCKED) begin
			rx_cnt_nxt = snf_pkg::CNT_ZERO; // see [RL10]
			tx_cnt_nxt = snf_pkg::CNT_ZERO;
		end
		oe_nxt = snf_pkg::OE_NONE;
		if (st_nxt == snf_pkg::ST_ACTIVE && i_drive_out) begin
			oe_nxt = oe_pat; // see [RL13]
		end
		paused_nxt = (st_nxt == snf_pkg::ST_PAUSED);
		overrun_nxt = overrun_r;
		if (st_r == snf_pkg::ST_IDLE && !cs_n_s) begin
			overrun_nxt = 1'b0;
		end
		// the host cannot be stalled, so a full buffer is only reported
		if (push_r && !rx_in.ready) begin
			overrun_nxt = 1'b1;
		end
		strobe_oe_nxt = (st_r == snf_pkg::ST_ACTIVE) && i_strobe_cmd; // see [RL17]
		strobe_nxt = strobe_oe_nxt && i_strobe_data_valid && sclk_s; // see [RL18]
		prot_ok_nxt = !(i_protect_bits_write_disable && !i_quad_io_enable
			&& !guard_s); // see [RL15] see [RL16]
		col_rd_nxt = (i_column_address <= snf_pkg::COL_LAST_ECC_OFF); // see [RL19]
		// spare bytes past the first 64 are read-only with ecc on
		col_pg_nxt = i_ecc_enable
			? (i_column_address <= snf_pkg::COL_LAST_ECC_ON) // see [RL21] see [RL23]
			: (i_column_address <= snf_pkg::COL_LAST_ECC_OFF); // see [RL22]
		page_nxt = i_row_address[snf_pkg::PAGE_W-1:0]; // see [RL20]
		block_nxt = i_row_address[snf_pkg::ROW_W-1:snf_pkg::PAGE_W];
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			st_r <= snf_pkg::ST_IDLE;
			mode3_r <= 1'b0;
			if_reset_r <= 1'b0;
			rx_sh_r <= 8'h00;
			rx_cnt_r <= snf_pkg::CNT_ZERO;
			rx_byte_r <= 8'h00;
			push_r <= 1'b0;
			tx_sh_r <= 8'h00;
			tx_cnt_r <= snf_pkg::CNT_ZERO;
			take_r <= 1'b0;
			io_r <= 4'h0;
			oe_r <= snf_pkg::OE_NONE;
			paused_r <= 1'b0;
			overrun_r <= 1'b0;
			strobe_r <= 1'b0;
			strobe_oe_r <= 1'b0;
			prot_ok_r <= 1'b1;
			col_rd_r <= 1'b0;
			col_pg_r <= 1'b0;
			page_r <= 6'h00;
			block_r <= 10'h000;
		end else begin
			st_r <= st_nxt;
			mode3_r <= mode3_nxt;
			if_reset_r <= if_reset_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_byte_r <= rx_byte_nxt;
			push_r <= push_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			take_r <= take_nxt;
			io_r <= io_nxt;
			oe_r <= oe_nxt;
			paused_r <= paused_nxt;
			overrun_r <= overrun_nxt;
			strobe_r <= strobe_nxt;
			strobe_oe_r <= strobe_oe_nxt;
			prot_ok_r <= prot_ok_nxt;
			col_rd_r <= col_rd_nxt;
			col_pg_r <= col_pg_nxt;
			page_r <= page_nxt;
			block_r <= block_nxt;
		end
	end

	assign o_data_io = io_r;
	assign o_data_io_oe = oe_r;
	assign o_read_strobe = strobe_r;
	assign o_read_strobe_oe = strobe_oe_r;
	assign o_tx_take = take_r;
	assign o_rx_overrun = overrun_r;
	assign o_paused = paused_r;
	assign o_if_reset = if_reset_r;
	assign o_mode3 = mode3_r;
	assign o_protect_write_ok = prot_ok_r;
	assign o_page_index = page_r;
	assign o_block_index = block_r;
	assign o_column_readable = col_rd_r;
	assign o_column_programmable = col_pg_r;

	deselect_idle_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [RL4]
		(st_r == snf_pkg::ST_ACTIVE && cs_n_s) |=> st_r == snf_pkg::ST_IDLE)
		else $error("active link did not go idle on deselect");
	pause_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [RL9]
		(st_r == snf_pkg::ST_ACTIVE && i_quad_io_enable) |=> st_r != snf_pkg::ST_PAUSED)
		else $error("pause entered with quad enable set");
	pause_start_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [RL11]
		(st_r == snf_pkg::ST_ACTIVE && !cs_n_s && !i_quad_io_enable && !pause_s
		&& !sclk_s) |=> (st_r == snf_pkg::ST_PAUSED && o_paused))
		else $error("pause did not start with clock low");
	pause_defer_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [RL12]
		(st_r == snf_pkg::ST_PAUSED && !cs_n_s && !i_quad_io_enable && sclk_s)
		|=> st_r == snf_pkg::ST_PAUSED)
		else $error("pause ended while clock high");
	pause_float_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [RL13]
		o_paused |-> (o_data_io_oe == snf_pkg::OE_NONE && !o_tx_take))
		else $error("data pins driven during pause");
	pause_reset_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [RL14]
		(st_r == snf_pkg::ST_PAUSED && cs_n_s) |=> (o_if_reset && st_r == snf_pkg::ST_LOCKED)
		##1 !o_if_reset)
		else $error("deselect in pause did not reset interface");
	guard_block_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [RL15]
		(i_protect_bits_write_disable && !i_quad_io_enable && !guard_s)
		|=> !o_protect_write_ok)
		else $error("protection write allowed with guard low");
	strobe_low_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [RL17]
		(st_r == snf_pkg::ST_ACTIVE && i_strobe_cmd && !i_strobe_data_valid)
		|=> (o_read_strobe_oe && !o_read_strobe))
		else $error("strobe not held low before data valid");
	spare_prog_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [RL21]
		(i_ecc_enable && i_column_address > snf_pkg::COL_LAST_ECC_ON)
		|=> !o_column_programmable)
		else $error("upper spare bytes programmable with ecc on");
	row_map_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [RL20]
		1'b1 |=> (o_page_index == $past(i_row_address[5:0])
		&& o_block_index == $past(i_row_address[15:6])))
		else $error("row address split wrong");
endmodule : snf_front_end
`default_nettype wire

// file: tb/snf_host_model.sv
// host flash controller model driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module snf_host_model (
	input wire logic i_clk,
	output logic o_cs_n,
	output logic o_sclk,
	output logic [3:0] o_io,
	output logic [3:0] o_io_oe
);
	logic m3;
	initial begin
		m3 = 1'b0;
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_io = 4'hf;
		o_io_oe = 4'hd;
	end
	// pins move just after a system edge so sampling never races
	task automatic tk(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tk
	task automatic sel(input logic mode3);
		m3 = mode3;
		o_sclk = mode3;
		o_io[3] = 1'b1;
		tk(4);
		o_cs_n = 1'b0;
		tk(4);
	endtask : sel
	task automatic desel();
		o_cs_n = 1'b1;
		tk(8);
	endtask : desel
	task automatic set_io(input int b, input logic v);
		o_io[b] = v;
		tk(1);
	endtask : set_io
	// msb first, w bits a unit, data set while the clock is low
	task automatic xfer(input logic [7:0] d, input int w, input int hi,
		input int lo);
		for (int i = hi; i >= lo; i -= w) begin
			o_sclk = 1'b0;
			for (int b = 0; b < w; b++) o_io[b] = d[i + b];
			o_io_oe = (w == 1) ? 4'hd : 4'hf;
			tk(4);
			o_sclk = 1'b1;
			tk(4);
		end
		if (!m3) o_sclk = 1'b0;
		if (w == 4) o_io[3:2] = 2'b11;
		o_io_oe = 4'hd;
		tk(4);
	endtask : xfer
	// double rate: high nibble rides the rise, low nibble the fall
	task automatic dtr(input logic [7:0] d);
		o_io_oe = 4'hf;
		o_io = d[7:4];
		tk(4);
		o_sclk = 1'b1;
		tk(4);
		o_io = d[3:0];
		tk(4);
		o_sclk = 1'b0;
		tk(4);
		o_io[3:2] = 2'b11;
		o_io_oe = 4'hd;
		tk(4);
	endtask : dtr
	task automatic clk_to(input logic v);
		o_sclk = v;
		tk(4);
	endtask : clk_to
endmodule : snf_host_model
`default_nettype wire

// file: tb/snf_front_end_tb_top.sv
// regression bench for the serial flash pin front end
`timescale 1ns/1ps
`default_nettype none
module snf_front_end_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic qe = 1'b0, ecc = 1'b1, pbwd = 1'b0, dout = 1'b0;
	logic scmd = 1'b0, sval = 1'b0, rdy = 1'b0, saw_rst = 1'b0;
	logic [7:0] txd = 8'h80;
	logic [11:0] col = 12'h000;
	logic [15:0] row = 16'h0000;
	snf_pkg::snf_width_e wid = snf_pkg::W_SINGLE;
	snf_pkg::snf_width_e ws [3] = '{snf_pkg::W_SINGLE, snf_pkg::W_DUAL,
		snf_pkg::W_QUAD};
	logic [7:0] bs [3] = '{8'ha5, 8'h3c, 8'h96};
	logic [11:0] cols [5] = '{12'h83f, 12'h840, 12'h87f, 12'h880, 12'hfff};
	logic cs_n, sclk, stb, stb_oe, take, rx_valid, overrun, paused;
	logic if_rst, mode3, pok, crd, cpg;
	logic [3:0] h_io, h_oe, d_io, d_oe, pin;
	logic [3:0] last_r = 4'hf;
	logic [7:0] rx_data;
	logic [5:0] page;
	logic [9:0] blk;
	int failures = 0, checks = 0, cyc = 0;
	int takes = 0;
	initial forever #5 clk = ~clk;
	// a line nobody drives keeps flipping so a stale value never passes
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin[i] = (d_oe[i] === 1'b1) ? d_io[i] :
				(h_oe[i] ? h_io[i] : ~last_r[i]);
		end
	end
	always @(posedge clk) begin
		last_r <= pin;
		if (if_rst === 1'b1) saw_rst <= 1'b1;
		if (take === 1'b1) takes++;
		cyc++;
		if (cyc == 20000) begin
			failures++;
			tally_and_finish();
		end
	end
	snf_host_model u_host (.i_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk),
		.o_io(h_io), .o_io_oe(h_oe));
	snf_front_end u_dut (.i_clk_sys(clk), .i_rst(rst), .i_cs_n(cs_n),
		.i_sclk(sclk), .i_data_io(pin), .o_data_io(d_io),
		.o_data_io_oe(d_oe), .o_read_strobe(stb),
		.o_read_strobe_oe(stb_oe), .i_quad_io_enable(qe),
		.i_ecc_enable(ecc), .i_protect_bits_write_disable(pbwd),
		.i_bus_width(wid), .i_drive_out(dout), .i_strobe_cmd(scmd),
		.i_strobe_data_valid(sval), .i_tx_data(txd), .o_tx_take(take),
		.o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rdy),
		.o_rx_overrun(overrun), .o_paused(paused), .o_if_reset(if_rst),
		.o_mode3(mode3), .o_protect_write_ok(pok),
		.i_column_address(col), .i_row_address(row), .o_page_index(page),
		.o_block_index(blk), .o_column_readable(crd),
		.o_column_programmable(cpg));
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tk
	task automatic cmp_b(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_b
	task automatic cmp_v(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_v
	task automatic tend(input string s);
		$display("test %s done", s);
	endtask : tend
	// the buffer holds a byte until ready, so the bench pops one by one
	task automatic pop(input logic [7:0] exp);
		for (int n = 0; n < 40 && rx_valid !== 1'b1; n++) tk(1);
		cmp_b(rx_valid, 1'b1);
		cmp_v(16'(rx_data), 16'(exp));
		rdy = 1'b1;
		tk(1);
		rdy = 1'b0;
		tk(1);
	endtask : pop
	task automatic tally_and_finish();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		tk(12);
		rst = 1'b0;
		tk(2);
		cmp_b(pok, 1'b1);
		cmp_v(16'(d_oe), 16'h0000);
		cmp_b(paused, 1'b0);
		tend("reset");
		for (int k = 0; k < 3; k++) begin
			wid = ws[k];
			qe = (k == 2);
			u_host.sel(1'b0);
			cmp_b(mode3, 1'b0);
			u_host.xfer(bs[k], 1 << k, 8 - (1 << k), 0);
			u_host.desel();
			pop(bs[k]);
		end
		u_host.sel(1'b0);
		u_host.set_io(3, 1'b0);
		tk(6);
		cmp_b(paused, 1'b0);
		u_host.set_io(3, 1'b1);
		u_host.desel();
		tend("widths");
		qe = 1'b0;
		wid = snf_pkg::W_SINGLE;
		u_host.sel(1'b0);
		u_host.xfer(8'h6b, 1, 7, 4);
		u_host.set_io(3, 1'b0);
		tk(6);
		cmp_b(paused, 1'b1);
		u_host.xfer(8'h00, 1, 7, 4);
		u_host.set_io(3, 1'b1);
		tk(6);
		cmp_b(paused, 1'b0);
		u_host.xfer(8'h6b, 1, 3, 0);
		u_host.desel();
		pop(8'h6b);
		tend("pause");
		dout = 1'b1;
		u_host.sel(1'b0);
		u_host.xfer(8'h00, 1, 7, 7);
		tk(2);
		cmp_b(d_io[1], 1'b1);
		cmp_v(16'(d_oe), 16'h0002);
		u_host.xfer(8'h00, 1, 7, 7);
		tk(2);
		cmp_b(d_io[1], 1'b0);
		cmp_v(16'(takes), 16'h0001);
		u_host.set_io(3, 1'b0);
		tk(6);
		cmp_v(16'(d_oe), 16'h0000);
		u_host.desel();
		cmp_b(saw_rst, 1'b1);
		cmp_b(paused, 1'b0);
		cmp_v(16'(d_oe), 16'h0000);
		tend("launch");
		qe = 1'b1;
		wid = snf_pkg::W_DTR;
		dout = 1'b0;
		u_host.sel(1'b0);
		u_host.dtr(8'hc5);
		u_host.desel();
		pop(8'hc5);
		dout = 1'b1;
		u_host.sel(1'b0);
		scmd = 1'b1;
		tk(3);
		cmp_b(stb_oe, 1'b1);
		cmp_b(stb, 1'b0);
		sval = 1'b1;
		u_host.clk_to(1'b1);
		cmp_b(stb, 1'b1);
		u_host.clk_to(1'b0);
		cmp_b(stb, 1'b0);
		scmd = 1'b0;
		sval = 1'b0;
		dout = 1'b0;
		u_host.desel();
		tend("strobe");
		for (int k = 0; k < 8; k++) begin
			{qe, pbwd} = k[1:0];
			u_host.set_io(2, k[2]);
			tk(6);
			cmp_b(pok, !(pbwd && !k[2] && !qe));
		end
		u_host.set_io(2, 1'b1);
		tend("guard");
		for (int k = 0; k < 10; k++) begin
			ecc = k[0];
			col = cols[k >> 1];
			row = 16'hbeef ^ 16'(k);
			tk(2);
			cmp_b(crd, col <= 12'h87f);
			cmp_b(cpg, col <= (ecc ? 12'h83f : 12'h87f));
			cmp_v(16'(page), 16'(row[5:0]));
			cmp_v(16'(blk), 16'(row[15:6]));
		end
		tend("address");
		qe = 1'b0;
		wid = snf_pkg::W_SINGLE;
		u_host.sel(1'b1);
		cmp_b(mode3, 1'b1);
		u_host.xfer(8'ha5, 1, 7, 0);
		u_host.xfer(8'h5a, 1, 7, 0);
		u_host.xfer(8'hc3, 1, 7, 0);
		u_host.desel();
		cmp_b(overrun, 1'b1);
		pop(8'ha5);
		pop(8'h5a);
		tend("overrun");
		tally_and_finish();
	end
endmodule : snf_front_end_tb_top
`default_nettype wire
